// ===== rtl/ct_regs.svh
// Register offsets, field positions and reset values of the control timer.
`ifndef CT_REGS_SVH
`define CT_REGS_SVH

`define CT_CW 24
`define CT_NCH 4

`define CT_OFS_CTRL1 8'h00
`define CT_OFS_CTRL2_SET 8'h04
`define CT_OFS_CTRL2_CLR 8'h08
`define CT_OFS_FAULT_A 8'h0c
`define CT_OFS_FAULT_B 8'h10
`define CT_OFS_WAVE_EXT 8'h14
`define CT_OFS_DRIVER 8'h18
`define CT_OFS_EVENT 8'h1c
`define CT_OFS_STATE 8'h20
`define CT_OFS_WAVE 8'h24
`define CT_OFS_COUNT 8'h28
`define CT_OFS_PERIOD 8'h2c
`define CT_OFS_PERIOD_BUF 8'h30
`define CT_OFS_PATTERN 8'h34
`define CT_OFS_PATTERN_BUF 8'h38
`define CT_OFS_DEBUG 8'h3c
`define CT_PAGE_CMP 4'h4
`define CT_PAGE_CMP_BUF 4'h5

`define CT_C1_SOFT_RESET_BIT 0
`define CT_C1_ENABLE 1
`define CT_C1_STDBY 6
`define CT_C1_PRESC 8
`define CT_C1_PSYNC 12
`define CT_C1_CAPT 24
`define CT_C2_DIR 0

`define CT_ST_ZERO 0
`define CT_ST_MAX 1
`define CT_ST_TOP 2
`define CT_ST_NRF 4
`define CT_ST_RF 6
`define CT_ST_PBV 8
`define CT_ST_PATBV 9
`define CT_ST_CBV 12

`define CT_EV_NRF_FILT 2
`define CT_EV_OVF_OUT 3
`define CT_EV_IRQ 4
`define CT_EV_DMA 5

`define CT_PSYNC_GCLK 2'h0
`define CT_HSIZE_WORD 3'h2
`define CT_RESET_VAL '0

`endif

// ===== rtl/ct_pkg.sv
// Types shared by the control timer design.
`default_nettype none
package ct_pkg;
`include "ct_regs.svh"

   typedef logic [`CT_CW-1:0] ct_cnt_t;

   typedef enum logic [2:0] {
      ct_fa_off,
      ct_fa_restart,
      ct_fa_halt,
      ct_fa_shorten,
      ct_fa_suppress
   } ct_fault_act_e;

   typedef struct packed {
      logic ph_wr;
      logic [7:0] ph_addr;
      logic [31:0] rdata;
      logic en;
      logic stdby;
      logic [2:0] presc;
      logic [1:0] psync;
      logic [3:0] capt;
      logic dir;
      logic [1:0][15:0] fctl;
      logic [19:0] wex;
      logic [23:0] drv;
      logic [5:0] evc;
      logic [7:0] wave;
      ct_cnt_t cnt;
      ct_cnt_t period;
      ct_cnt_t period_buf;
      logic pbv;
      logic [3:0][`CT_CW-1:0] cmp;
      logic [3:0][`CT_CW-1:0] cmp_buf;
      logic [3:0] cbv;
      logic [15:0] patt;
      logic [15:0] patt_buf;
      logic patbv;
      logic dbg;
      logic [9:0] pcnt;
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [1:0][3:0] fcnt;
      logic [1:0][7:0] blank;
      logic [1:0] rf;
      logic [1:0] shortn;
      logic [1:0] nrf;
      logic [3:0] dtp;
      logic [3:0][7:0] dtc;
      logic [3:0] lo;
      logic [3:0] hi;
      logic upd;
   } ct_state_s;
endpackage
`default_nettype wire

// ===== rtl/ct_control_timer.sv
// Control timer core with AHB-Lite register slave and waveform extensions.
//
// Operation
// - Top is the period value, or channel zero's value in match mode.
// - Zero is flagged when every counter bit is clear.
// - Maximum is flagged when every counter bit is set.
// - Update fires at top counting up, at zero counting down.
// - Four channels, each compare or capture.
// - Counter, period and channel registers are 24 bits wide.
// - Each buffer register has a valid flag until transferred.
// - Reaching top or zero can raise interrupt, DMA or event output.
// - Recoverable faults restart, halt, shorten the pulse or suppress outputs.
// - Channel events feed the recoverable faults, not capture, when enabled.
// - Recoverable faults are filtered, blanked and qualified.
// - Dead-time stage splits four outputs into non-overlapping low and high sides.
// - Swap stage exchanges a pair's low and high side outputs.
// - Pattern levels drive outputs, new levels taken at update.
// - A non-recoverable fault forces outputs to configured safe values.
// - Unfiltered counter-event faults act on the pins without a clock.
// - Protected registers are written only while disabled.
// - Protected first-control bits may join a write that sets enable.
// - Writing enable one starts, writing zero stops the timer.
// - Soft reset restores all registers but debug control, disabled.
// - Direction zero counts up, one counts down.
`timescale 1ns/1ps
`default_nettype none

module ct_control_timer
(
   input wire logic hclk, // Bus and count clock.
   input wire logic hresetn, // Asynchronous reset, active low.
   input wire logic hsel, // Slave select.
   input wire logic [31:0] haddr, // Byte address.
   input wire logic [1:0] htrans, // Transfer type.
   input wire logic hwrite, // Write when high.
   input wire logic [2:0] hsize, // Transfer size.
   input wire logic [31:0] hwdata, // Write data.
   input wire logic hready, // Bus ready.
   output logic hreadyout, // Slave ready.
   output logic hresp, // Response, always okay.
   output logic [31:0] hrdata, // Read data.
   input wire logic channel_event_a, // Channel event, recoverable fault a.
   input wire logic channel_event_b, // Channel event, recoverable fault b.
   input wire logic counter_event_a, // Counter event, non-recoverable fault a.
   input wire logic counter_event_b, // Counter event, non-recoverable fault b.
   input wire logic debug_halt, // Processor halted in debug.
   output logic [3:0] low_side_out, // Low side waveform pins.
   output logic [3:0] high_side_out, // High side waveform pins.
   output logic update_pulse, // Update condition pulse.
   output logic irq_req, // Overflow interrupt request pulse.
   output logic dma_req, // Overflow DMA request pulse.
   output logic overflow_event_out, // Overflow event pulse.
   output logic enabled // Timer enabled.
);
   import ct_pkg::*;

   ct_state_s q;
   ct_state_s d;
   logic [15:0] fc;
   logic [3:0] wv;
   logic [3:0] wg;
   logic [3:0] om;
   logic [1:0] rise;
   logic [1:0] rf;
   logic [1:0] act_restart;
   logic restart;
   logic hold;
   logic tick;
   logic upd_now;
   logic [7:0] v;
   logic [1:0] nrf_act;
   logic [7:0] force_on;

   function automatic ct_cnt_t top_of(input ct_state_s s);
      top_of = s.wave[0] ? s.cmp[0] : s.period;
   endfunction

   function automatic logic [9:0] presc_lim(input logic [2:0] sel);
      case (sel)
         3'h0: presc_lim = 10'h000;
         3'h1: presc_lim = 10'h001;
         3'h2: presc_lim = 10'h003;
         3'h3: presc_lim = 10'h007;
         3'h4: presc_lim = 10'h00f;
         3'h5: presc_lim = 10'h03f;
         3'h6: presc_lim = 10'h0ff;
         default: presc_lim = 10'h3ff;
      endcase
   endfunction

   // Routes the channel waveforms onto the four matrix outputs; only mode zero passes all four.
   function automatic logic [3:0] matrix(input logic [1:0] m, input logic [3:0] w);
      case (m)
         2'h0: matrix = w;
         2'h1: matrix = {w[1], w[0], w[1], w[0]};
         2'h2: matrix = {4{w[0]}};
         default: matrix = {w[1], w[1], w[1], w[0]};
      endcase
   endfunction

   function automatic logic [31:0] rd(input ct_state_s s, input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      if (a == `CT_OFS_CTRL1)
      begin
         r[`CT_C1_ENABLE] = s.en;
         r[`CT_C1_STDBY] = s.stdby;
         r[`CT_C1_PRESC +: 3] = s.presc;
         r[`CT_C1_PSYNC +: 2] = s.psync;
         r[`CT_C1_CAPT +: 4] = s.capt;
      end
      else if (a == `CT_OFS_CTRL2_SET || a == `CT_OFS_CTRL2_CLR)
         r[`CT_C2_DIR] = s.dir;
      else if (a == `CT_OFS_FAULT_A)
         r[15:0] = s.fctl[0];
      else if (a == `CT_OFS_FAULT_B)
         r[15:0] = s.fctl[1];
      else if (a == `CT_OFS_WAVE_EXT)
         r[19:0] = s.wex;
      else if (a == `CT_OFS_DRIVER)
         r[23:0] = s.drv;
      else if (a == `CT_OFS_EVENT)
         r[5:0] = s.evc;
      else if (a == `CT_OFS_STATE)
      begin
         r[`CT_ST_ZERO] = (s.cnt == '0);
         r[`CT_ST_MAX] = &s.cnt;
         r[`CT_ST_TOP] = (s.cnt == top_of(s));
         r[`CT_ST_NRF +: 2] = s.nrf;
         r[`CT_ST_RF +: 2] = s.rf;
         r[`CT_ST_PBV] = s.pbv;
         r[`CT_ST_PATBV] = s.patbv;
         r[`CT_ST_CBV +: 4] = s.cbv;
      end
      else if (a == `CT_OFS_WAVE)
         r[7:0] = s.wave;
      else if (a == `CT_OFS_COUNT)
         r[`CT_CW-1:0] = s.cnt;
      else if (a == `CT_OFS_PERIOD)
         r[`CT_CW-1:0] = s.period;
      else if (a == `CT_OFS_PERIOD_BUF)
         r[`CT_CW-1:0] = s.period_buf;
      else if (a == `CT_OFS_PATTERN)
         r[15:0] = s.patt;
      else if (a == `CT_OFS_PATTERN_BUF)
         r[15:0] = s.patt_buf;
      else if (a == `CT_OFS_DEBUG)
         r[0] = s.dbg;
      else if (a[7:4] == `CT_PAGE_CMP)
         r[`CT_CW-1:0] = s.cmp[a[3:2]];
      else if (a[7:4] == `CT_PAGE_CMP_BUF)
         r[`CT_CW-1:0] = s.cmp_buf[a[3:2]];
      rd = r;
   endfunction

   // Unfiltered faults bypass every flip-flop so pins go safe at once.
   assign nrf_act = q.evc[1:0] & (q.nrf | (q.evc[`CT_EV_NRF_FILT] ? 2'b00 :
      {counter_event_b, counter_event_a}));
   assign force_on = (|nrf_act) ? q.drv[7:0] : 8'h00;

   // Safe values override the registered outputs.
   assign low_side_out = (force_on[3:0] & q.drv[11:8]) | (~force_on[3:0] & q.lo);
   assign high_side_out = (force_on[7:4] & q.drv[15:12]) | (~force_on[7:4] & q.hi);

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = q.rdata;
   assign enabled = q.en;
   assign update_pulse = q.upd;
   // Overflow requests follow the update condition.
   assign irq_req = q.upd & q.evc[`CT_EV_IRQ];
   assign dma_req = q.upd & q.evc[`CT_EV_DMA];
   assign overflow_event_out = q.upd & q.evc[`CT_EV_OVF_OUT];

   always_comb
   begin
      d = q;
      fc = 16'h0000;
      rf = 2'b00;
      act_restart = 2'b00;
      tick = 1'b0;
      upd_now = 1'b0;
      restart = 1'b0;
      d.upd = 1'b0;

      d.s1 = {counter_event_b, counter_event_a, channel_event_b, channel_event_a};
      d.s2 = q.s1;
      d.s3 = q.s2;
      rise = q.s2[1:0] & ~q.s3[1:0];

      // Compare waveforms; a capture channel stays inactive.
      for (int i = 0; i < `CT_NCH; i++)
         wv[i] = (q.en & ~q.capt[i] & (q.cnt < q.cmp[i])) ^ q.wave[4 + i];

      for (int u = 0; u < 2; u++)
      begin
         fc = q.fctl[u];
         // Filter counts consecutive samples, blanking follows update.
         if (q.s2[u])
         begin
            if (q.fcnt[u] != fc[7:4])
               d.fcnt[u] = q.fcnt[u] + 4'h1;
         end
         else
            d.fcnt[u] = 4'h0;
         if (q.blank[u] != 8'h00)
            d.blank[u] = q.blank[u] - 8'h01;
         // Qualified by the channel's own waveform when selected.
         rf[u] = q.en && q.s2[u] && q.fcnt[u] == fc[7:4] && q.blank[u] == 8'h00 &&
            (!fc[3] || wv[u]) && fc[2:0] != ct_fa_off;
         act_restart[u] = rf[u] && !q.rf[u] && fc[2:0] == ct_fa_restart;
         // Shorten holds the channel inactive until the next update.
         if (rf[u] && fc[2:0] == ct_fa_shorten)
            d.shortn[u] = 1'b1;
      end
      d.rf = rf;
      restart = |act_restart;

      wg = wv;
      for (int u = 0; u < 2; u++)
      begin
         // Suppression lasts while the fault persists.
         if (q.shortn[u] || (rf[u] && q.fctl[u][2:0] == ct_fa_suppress))
            wg[u] = 1'b0;
      end

      // Halt freezes the count while the fault stands.
      hold = !q.en || (rf[0] && q.fctl[0][2:0] == ct_fa_halt) ||
         (rf[1] && q.fctl[1][2:0] == ct_fa_halt) || (|q.nrf) || (debug_halt && !q.dbg);

      if (!hold)
      begin
         if (q.pcnt == presc_lim(q.presc))
         begin
            d.pcnt = 10'h000;
            tick = 1'b1;
         end
         else
            d.pcnt = q.pcnt + 10'h001;
      end

      // Restart begins a fresh counting period.
      if (restart)
      begin
         d.cnt = q.dir ? top_of(q) : '0;
         if (q.psync != `CT_PSYNC_GCLK)
            d.pcnt = 10'h000;
      end
      else if (tick)
      begin
         // Direction selects up or down counting.
         if (!q.dir)
         begin
            // Update at top when counting up.
            if (q.cnt == top_of(q))
            begin
               d.cnt = '0;
               upd_now = 1'b1;
            end
            else
               d.cnt = q.cnt + 24'h1;
         end
         else
         begin
            // Update at zero when counting down.
            if (q.cnt == '0)
            begin
               d.cnt = top_of(q);
               upd_now = 1'b1;
            end
            else
               d.cnt = q.cnt - 24'h1;
         end
      end
      d.upd = upd_now;

      if (upd_now)
      begin
         for (int u = 0; u < 2; u++)
            d.shortn[u] = rf[u] && q.fctl[u][2:0] == ct_fa_shorten;
         d.blank[0] = q.fctl[0][15:8];
         d.blank[1] = q.fctl[1][15:8];
         // Valid buffers move into their registers at update.
         if (q.pbv)
         begin
            d.period = q.period_buf;
            d.pbv = 1'b0;
         end
         for (int i = 0; i < `CT_NCH; i++)
         begin
            if (q.cbv[i])
            begin
               d.cmp[i] = q.cmp_buf[i];
               d.cbv[i] = 1'b0;
            end
         end
         // New pattern levels are taken at update.
         if (q.patbv)
         begin
            d.patt = q.patt_buf;
            d.patbv = 1'b0;
         end
      end

      // An event owned by a recoverable fault does not capture.
      for (int i = 0; i < `CT_NCH; i++)
      begin
         if (q.en && q.capt[i] && rise[i % 2] && q.fctl[i % 2][2:0] == ct_fa_off)
            d.cmp[i] = q.cnt;
      end

      if (hsel && htrans[1] && hready && hsize == `CT_HSIZE_WORD)
      begin
         d.ph_wr = hwrite;
         d.ph_addr = {haddr[7:2], 2'b00};
         if (!hwrite)
            d.rdata = rd(q, {haddr[7:2], 2'b00});
      end
      else
         d.ph_wr = 1'b0;

      // Bus writes land in the data phase and win over counting.
      if (q.ph_wr)
      begin
         if (q.ph_addr == `CT_OFS_CTRL1)
         begin
            d.en = hwdata[`CT_C1_ENABLE];
            d.stdby = hwdata[`CT_C1_STDBY];
            // Protected bits ride only on a write made while disabled.
            if (!q.en)
            begin
               d.presc = hwdata[`CT_C1_PRESC +: 3];
               d.psync = hwdata[`CT_C1_PSYNC +: 2];
               d.capt = hwdata[`CT_C1_CAPT +: 4];
            end
         end
         else if (q.ph_addr == `CT_OFS_CTRL2_SET)
         begin
            if (hwdata[`CT_C2_DIR])
               d.dir = 1'b1;
         end
         else if (q.ph_addr == `CT_OFS_CTRL2_CLR)
         begin
            if (hwdata[`CT_C2_DIR])
               d.dir = 1'b0;
         end
         // Fault, extension, driver and event control need disable.
         // Otherwise the write is dropped without error.
         else if (q.ph_addr == `CT_OFS_FAULT_A)
         begin
            if (!q.en)
               d.fctl[0] = hwdata[15:0];
         end
         else if (q.ph_addr == `CT_OFS_FAULT_B)
         begin
            if (!q.en)
               d.fctl[1] = hwdata[15:0];
         end
         else if (q.ph_addr == `CT_OFS_WAVE_EXT)
         begin
            if (!q.en)
               d.wex = hwdata[19:0];
         end
         else if (q.ph_addr == `CT_OFS_DRIVER)
         begin
            if (!q.en)
               d.drv = hwdata[23:0];
         end
         else if (q.ph_addr == `CT_OFS_EVENT)
         begin
            if (!q.en)
               d.evc = hwdata[5:0];
         end
         else if (q.ph_addr == `CT_OFS_STATE)
            d.nrf = q.nrf & ~hwdata[`CT_ST_NRF +: 2];
         else if (q.ph_addr == `CT_OFS_WAVE)
            d.wave = hwdata[7:0];
         // Counter and channel registers keep 24 bits.
         else if (q.ph_addr == `CT_OFS_COUNT)
            d.cnt = hwdata[`CT_CW-1:0];
         else if (q.ph_addr == `CT_OFS_PERIOD)
            d.period = hwdata[`CT_CW-1:0];
         else if (q.ph_addr == `CT_OFS_PERIOD_BUF)
         begin
            // A buffer write marks the buffer valid.
            d.period_buf = hwdata[`CT_CW-1:0];
            d.pbv = 1'b1;
         end
         else if (q.ph_addr == `CT_OFS_PATTERN)
            d.patt = hwdata[15:0];
         else if (q.ph_addr == `CT_OFS_PATTERN_BUF)
         begin
            d.patt_buf = hwdata[15:0];
            d.patbv = 1'b1;
         end
         else if (q.ph_addr == `CT_OFS_DEBUG)
            d.dbg = hwdata[0];
         else if (q.ph_addr[7:4] == `CT_PAGE_CMP)
            d.cmp[q.ph_addr[3:2]] = hwdata[`CT_CW-1:0];
         else if (q.ph_addr[7:4] == `CT_PAGE_CMP_BUF)
         begin
            d.cmp_buf[q.ph_addr[3:2]] = hwdata[`CT_CW-1:0];
            d.cbv[q.ph_addr[3:2]] = 1'b1;
         end
      end

      // Fault latch; a new fault wins over a clearing write.
      for (int k = 0; k < 2; k++)
      begin
         if (q.evc[k] && q.s2[2 + k] && (q.s3[2 + k] || !q.evc[`CT_EV_NRF_FILT]))
            d.nrf[k] = 1'b1;
      end

      // Dead time holds both sides low after each matrix edge.
      om = matrix(q.wex[1:0], wg);
      for (int i = 0; i < 4; i++)
      begin
         if (om[i] != q.dtp[i])
         begin
            d.dtp[i] = om[i];
            d.dtc[i] = q.wex[4 + i] ? q.wex[15:8] : 8'h00;
         end
         else if (q.dtc[i] != 8'h00)
            d.dtc[i] = q.dtc[i] - 8'h01;
         v[i] = q.dtp[i] & (q.dtc[i] == 8'h00);
         v[4 + i] = ~q.dtp[i] & (q.dtc[i] == 8'h00);
      end
      for (int i = 0; i < 4; i++)
      begin
         // Swap exchanges the pair's two sides.
         if (q.wex[16 + i])
            {v[i], v[4 + i]} = {v[4 + i], v[i]};
      end
      v = (q.patt[7:0] & q.patt[15:8]) | (~q.patt[7:0] & v);
      v = v ^ q.drv[23:16];
      d.lo = v[3:0];
      d.hi = v[7:4];

      // Soft reset clears everything but debug control and the event synchronizers, and disables.
      if (q.ph_wr && q.ph_addr == `CT_OFS_CTRL1 && hwdata[`CT_C1_SOFT_RESET_BIT])
      begin
         d = `CT_RESET_VAL;
         d.dbg = q.dbg;
         d.s1 = q.s1;
         d.s2 = q.s1;
         d.s3 = q.s2;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         q <= `CT_RESET_VAL;
      else
         q <= d;
   end
endmodule

`default_nettype wire

// ===== testbench/ct_checker.sv
// Port checks bound onto the control timer core.
`timescale 1ns/1ps
`default_nettype none

module ct_checker
(
   input wire logic hclk, // Clock.
   input wire logic hresetn, // Reset.
   input wire logic hsel, // Select.
   input wire logic [31:0] haddr, // Address.
   input wire logic [1:0] htrans, // Transfer.
   input wire logic hwrite, // Write.
   input wire logic [2:0] hsize, // Size.
   input wire logic [31:0] hwdata, // Write data.
   input wire logic hready, // Ready in.
   input wire logic hreadyout, // Ready out.
   input wire logic hresp, // Response.
   input wire logic update_pulse, // Update.
   input wire logic irq_req, // Interrupt.
   input wire logic dma_req, // DMA.
   input wire logic overflow_event_out, // Event.
   input wire logic enabled // Enabled.
);
   logic c1_q;

   // Marks the data phase of a word write to the first control register.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         c1_q <= 1'b0;
      else if (hready)
         c1_q <= hsel && htrans[1] && hwrite && hsize == 3'h2 && haddr[7:2] == 6'h00;
   end

   default clocking dcb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_resp_okay: assert property (!hresp && hreadyout)
      else $error("slave stalled or answered an error");
   a_irq_with_update: assert property (irq_req |-> update_pulse)
      else $error("interrupt request without update");
   a_dma_with_update: assert property (dma_req |-> update_pulse)
      else $error("dma request without update");
   a_event_with_update: assert property (overflow_event_out |-> update_pulse)
      else $error("overflow event without update");
   a_update_when_on: assert property (update_pulse |-> $past(enabled))
      else $error("update while stopped");
   a_enable_by_write: assert property (c1_q && hwdata[1] && !hwdata[0] |=> enabled)
      else $error("enable write did not start the timer");
   a_disable_by_write: assert property (c1_q && !hwdata[1] |=> !enabled)
      else $error("disable write left the timer on");
   a_soft_reset_off: assert property (c1_q && hwdata[0] |=> !enabled)
      else $error("soft reset left the timer on");
   a_rise_from_write: assert property ($rose(enabled) |-> $past(c1_q) && $past(hwdata[1]))
      else $error("timer started without a write");
   a_stop_quiet: assert property ($fell(enabled) |-> ##2 !update_pulse [*3])
      else $error("update after the timer stopped");

   c_started: cover property ($rose(enabled));
   c_update: cover property (update_pulse && irq_req);
   c_soft_reset: cover property (c1_q && hwdata[0]);
endmodule

bind ct_control_timer ct_checker u_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .update_pulse(update_pulse),
   .irq_req(irq_req), .dma_req(dma_req), .overflow_event_out(overflow_event_out),
   .enabled(enabled));

`default_nettype wire

// ===== testbench/ct_drive_model.sv
// Power-stage and event-source model facing the control timer pins.
`timescale 1ns/1ps
`default_nettype none

module ct_drive_model
(
   input wire logic hclk, // Timer clock.
   input wire logic [1:0] rf_req, // Recoverable fault requests.
   input wire logic [1:0] nrf_req, // Non-recoverable fault requests.
   input wire logic [3:0] low_side_out, // Low side pins.
   input wire logic [3:0] high_side_out, // High side pins.
   output logic channel_event_a, // Channel event a.
   output logic channel_event_b, // Channel event b.
   output logic counter_event_a, // Counter event a.
   output logic counter_event_b, // Counter event b.
   output logic [7:0] overlap_count // Samples with both sides on.
);
   initial
   begin
      {channel_event_b, channel_event_a, counter_event_b, counter_event_a} = 4'h0;
      overlap_count = 8'h00;
   end

   // asynchronous event routing
   // Events move well away from the rising edge, as an asynchronous path delivers them.
   always @(negedge hclk)
   begin
      #7;
      {channel_event_b, channel_event_a} <= rf_req;
      {counter_event_b, counter_event_a} <= nrf_req;
   end

   always @(negedge hclk)
   begin
      if ((low_side_out & high_side_out) !== 4'h0 && overlap_count != 8'hff)
         overlap_count <= overlap_count + 8'h01;
   end
endmodule

`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the control timer core.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic [31:0] rdata;
   } ct_row_s;

   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic debug_halt = 1'b0;
   logic [1:0] rf_req = 2'h0;
   logic [1:0] nrf_req = 2'h0;
   logic hready;
   logic hresp;
   logic [31:0] hrdata;
   logic ch_a;
   logic ch_b;
   logic ce_a;
   logic ce_b;
   logic [3:0] lo;
   logic [3:0] hi;
   logic upd;
   logic irq;
   logic dma;
   logic ovf;
   logic en;
   logic [7:0] overlaps;
   logic [31:0] rd;
   logic [31:0] rd2;
   logic [2:0] fl;
   int gap;
   int cycles = 0;
   int mismatches = 0;
   int samples_checked = 0;
   ct_row_s rows [0:17] = '{
      '{8'h0c, 32'ha1f1, 32'ha1f1}, '{8'h10, 32'h2a9a, 32'h2a9a}, '{8'h0c, 32'h533, 32'h533},
      '{8'h10, 32'hff44, 32'hff44}, '{8'h10, 32'h0, 32'h0}, '{8'h14, 32'hf1ff3, 32'hf1ff3},
      '{8'h18, 32'habcdef, 32'habcdef}, '{8'h1c, 32'h3f, 32'h3f},
      '{8'h2c, 32'hff123456, 32'h123456}, '{8'h28, 32'hffffffff, 32'hffffff},
      '{8'h20, 32'h0, 32'h2}, '{8'h28, 32'h0, 32'h0}, '{8'h20, 32'h0, 32'h1},
      '{8'h30, 32'h55, 32'h55}, '{8'h50, 32'h77, 32'h77}, '{8'h20, 32'h0, 32'h1101},
      '{8'h3c, 32'h1, 32'h1}, '{8'h7c, 32'hffffffff, 32'h0}};

   ct_control_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .channel_event_a(ch_a),
      .channel_event_b(ch_b), .counter_event_a(ce_a), .counter_event_b(ce_b),
      .debug_halt(debug_halt), .low_side_out(lo), .high_side_out(hi), .update_pulse(upd),
      .irq_req(irq), .dma_req(dma), .overflow_event_out(ovf), .enabled(en));

   ct_drive_model u_model (.hclk(hclk), .rf_req(rf_req), .nrf_req(nrf_req), .low_side_out(lo),
      .high_side_out(hi), .channel_event_a(ch_a), .channel_event_b(ch_b),
      .counter_event_a(ce_a), .counter_event_b(ce_b), .overlap_count(overlaps));

   initial
   begin
      forever #50 hclk = ~hclk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // One single word transfer; the answer is taken at the data-phase edge.
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do
         @(posedge hclk);
      while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      do
         @(posedge hclk);
      while (hready !== 1'b1);
      r = hrdata;
   endtask

   task automatic next_update(output int n, output logic [2:0] f);
      n = 0;
      do
      begin
         @(negedge hclk);
         n++;
      end
      while (upd !== 1'b1 && n < 60);
      f = {irq, dma, ovf};
   endtask

   always @(posedge hclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end

   initial
   begin
      repeat (3) @(posedge hclk);
      check("reset pins", {en, upd, irq, dma, ovf, hi, lo}, 32'h0);
      check("reset data", hrdata, 32'h0);
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (rows[i])
      begin
         ahb(1'b1, rows[i].addr, rows[i].wdata, rd);
         ahb(1'b0, rows[i].addr, 32'h0, rd);
         check($sformatf("reg %h", rows[i].addr), rd, rows[i].rdata);
      end
      ahb(1'b1, 8'h00, 32'h3000102, rd);
      ahb(1'b0, 8'h00, 32'h0, rd);
      check("ctrl on", rd, 32'h3000102);
      check("enabled", {31'h0, en}, 32'h1);
      ahb(1'b1, 8'h0c, 32'h4, rd);
      ahb(1'b0, 8'h0c, 32'h0, rd);
      check("fault locked", rd, 32'h533);
      ahb(1'b1, 8'h00, 32'h42, rd);
      ahb(1'b0, 8'h00, 32'h0, rd);
      check("ctrl locked", rd, 32'h3000142);
      ahb(1'b1, 8'h00, 32'h0, rd);
      ahb(1'b0, 8'h00, 32'h0, rd);
      check("ctrl off", rd, 32'h3000100);
      ahb(1'b1, 8'h00, 32'h1, rd);
      ahb(1'b0, 8'h2c, 32'h0, rd);
      check("period cleared", rd, 32'h0);
      ahb(1'b0, 8'h3c, 32'h0, rd);
      check("debug kept", rd, 32'h1);
      ahb(1'b1, 8'h2c, 32'h4, rd);
      ahb(1'b1, 8'h1c, 32'h38, rd);
      ahb(1'b1, 8'h00, 32'h2, rd);
      next_update(gap, fl);
      next_update(gap, fl);
      check("up gap", gap, 5);
      check("pulses", fl, 3'h7);
      ahb(1'b0, 8'h28, 32'h0, rd);
      ahb(1'b0, 8'h28, 32'h0, rd2);
      check("count up", rd2, (rd + 32'h3) % 32'h5);
      ahb(1'b1, 8'h00, 32'h0, rd);
      ahb(1'b1, 8'h04, 32'h1, rd);
      ahb(1'b1, 8'h00, 32'h2, rd);
      ahb(1'b0, 8'h04, 32'h0, rd);
      check("direction", rd, 32'h1);
      next_update(gap, fl);
      next_update(gap, fl);
      check("down gap", gap, 5);
      ahb(1'b0, 8'h28, 32'h0, rd);
      ahb(1'b0, 8'h28, 32'h0, rd2);
      check("count down", rd2, (rd + 32'h2) % 32'h5);
      check("overlap", overlaps, 8'h0);
      ahb(1'b1, 8'h00, 32'h0, rd);
      ahb(1'b1, 8'h18, 32'h111, rd);
      ahb(1'b1, 8'h1c, 32'h1, rd);
      @(negedge hclk);
      nrf_req = 2'h1;
      #30;
      check("forced pins", {hi[0], lo[0]}, 2'h1);
      @(negedge hclk);
      nrf_req = 2'h0;
      repeat (4) @(negedge hclk);
      check("held pins", {hi[0], lo[0]}, 2'h1);
      ahb(1'b0, 8'h20, 32'h0, rd);
      check("fault latched", rd & 32'h30, 32'h10);
      ahb(1'b1, 8'h20, 32'h10, rd);
      ahb(1'b0, 8'h20, 32'h0, rd);
      check("fault cleared", rd & 32'h30, 32'h0);
      tally_and_finish();
   end
endmodule

`default_nettype wire
